/* File: inc/sarcc_defs.svh */
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef SARCC_DEFS_SVH
`define SARCC_DEFS_SVH

`define SARCC_OFS_SC1      4'h0
`define SARCC_OFS_SC2      4'h1
`define SARCC_OFS_RESHI    4'h2
`define SARCC_OFS_RESLO    4'h3
`define SARCC_OFS_CMPHI    4'h4
`define SARCC_OFS_CMPLO    4'h5
`define SARCC_OFS_CFG      4'h6
`define SARCC_OFS_PINHI    4'h7

`define SARCC_SC1_DONE     7
`define SARCC_SC1_IEN      6
`define SARCC_SC1_CONT     5
`define SARCC_SC2_HWTEN    5
`define SARCC_SC2_CMPEN    4
`define SARCC_SC2_CMPGT    3
`define SARCC_CFG_DIV      5
`define SARCC_CFG_MODE     2
`define SARCC_CFG_CLK      0

`define SARCC_CH_OFF       5'h1f
`define SARCC_MODE_8       2'h0
`define SARCC_MODE_10      2'h2
`define SARCC_CLK_BUS      2'h0
`define SARCC_CLK_HALF     2'h1
`define SARCC_CLK_ALT      2'h2
`define SARCC_CLK_ASYNC    2'h3

`define SARCC_SC1_RESET    8'h1f
`define SARCC_SAMPLE_TICKS 4'h4
`define SARCC_BITS_10      4'hb
`define SARCC_BITS_8       4'h9

`endif

/* File: inc/sarcc_pkg.sv */
// Types of the converter control: bus request, FSM states and the state record
package sarcc_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sarcc_bus_s;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SAMPLE = 4'b0010,
        ST_CONV   = 4'b0100,
        ST_STORE  = 4'b1000
    } sarcc_state_e;

    typedef struct packed {
        sarcc_state_e st;
        logic         done;
        logic         ien;
        logic         cont;
        logic [4:0]   ch;
        logic         hwtEn;
        logic         cmpEn;
        logic         cmpGt;
        logic [1:0]   div;
        logic [1:0]   mode;
        logic [1:0]   clkSel;
        logic [9:0]   cmpVal;
        logic [7:0]   pinHigh;
        logic [1:0]   resHi;
        logic [7:0]   resLo;
        logic [7:0]   rdData;
        logic         trgSync1;
        logic         trgSync2;
        logic         trgPrev;
        logic         halfTog;
        logic         altPrev;
        logic [7:0]   asyncCnt;
        logic [2:0]   divCnt;
        logic [3:0]   tickCnt;
        logic [3:0]   bitIdx;
        logic [10:0]  dac;
        logic [10:0]  raw;
        logic         series;
    } sarcc_state_s;

endpackage

/* File: logic/sarcc_top.sv */
// Successive-approximation converter control: registers, clocking, trigger, sequencing, pins
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "sarcc_defs.svh"

module sarcc_top
    import sarcc_pkg::*;
#(
    parameter logic [7:0] ASYNC_DIV = 8'h05
)(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire sarcc_bus_s busReq,
    output logic [7:0]      rdData,
    output logic            irq,
    input  wire logic       alternate_clock,
    input  wire logic       lowPowerMode,
    input  wire logic       hwTriggerInput,
    output logic [4:0]      anaChannel,
    output logic            anaPowerOn,
    output logic            anaSample,
    output logic [10:0]     dacCode,
    input  wire logic       cmpIn,
    output logic            compareHit,
    input  wire logic [7:0] gpioOut,
    input  wire logic [7:0] gpioOe,
    input  wire logic [7:0] gpioPullEn,
    input  wire logic [7:0] padIn,
    output logic [7:0]      padOut,
    output logic [7:0]      padOe,
    output logic [7:0]      padPullEn,
    output logic [7:0]      gpioIn
);

    sarcc_state_s state_reg;
    sarcc_state_s state_next;

    logic        trigEdge;
    logic        srcTick;
    logic        adckTick;
    logic [2:0]  divMax;
    logic [3:0]  nBits;
    logic [9:0]  rounded;
    logic [9:0]  cmpRef;
    logic [9:0]  diff;
    logic        cmpTrue;
    logic        keep;
    logic        wrSc1;
    logic        wrMode;
    logic [10:0] dacTry;

    // Round an approximation half up to the stored width, saturating at full scale
    function automatic logic [9:0] sarcc_round(input logic [10:0] raw, input logic ten);
        logic [11:0] sum;
        sum = {1'b0, raw} + 12'h001;
        if (ten) begin
            sarcc_round = sum[11] ? 10'h3ff : sum[10:1];
        end else begin
            sarcc_round = sum[9] ? 10'h0ff : {2'h0, sum[8:1]};
        end
    endfunction

    assign padOut    = gpioOut;
    assign padOe     = gpioOe & ~state_reg.pinHigh;
    assign padPullEn = gpioPullEn & ~state_reg.pinHigh;
    assign gpioIn    = padIn & ~state_reg.pinHigh;

    assign rdData     = state_reg.rdData;
    assign irq        = state_reg.done & state_reg.ien;
    assign anaChannel = state_reg.ch;
    assign anaPowerOn = state_reg.st != ST_IDLE;
    assign anaSample  = state_reg.st == ST_SAMPLE;
    assign dacCode    = state_reg.dac;

    always_comb begin
        state_next = state_reg;
        state_next.trgSync1 = hwTriggerInput;
        state_next.trgSync2 = state_reg.trgSync1;
        state_next.trgPrev  = state_reg.trgSync2;
        trigEdge = state_reg.trgSync2 & ~state_reg.trgPrev;

        // Source ticks; bus-derived and alternate sources stop in low power, the async one does not
        state_next.halfTog = ~state_reg.halfTog;
        state_next.altPrev = alternate_clock;
        if (state_reg.clkSel == `SARCC_CLK_ASYNC) begin
            state_next.asyncCnt = (state_reg.asyncCnt == ASYNC_DIV - 8'h01) ? 8'h00
                                  : state_reg.asyncCnt + 8'h01;
        end else begin
            state_next.asyncCnt = 8'h00;
        end
        unique case (state_reg.clkSel)
            `SARCC_CLK_BUS:  srcTick = ~lowPowerMode;
            `SARCC_CLK_HALF: srcTick = ~lowPowerMode & state_reg.halfTog;
            `SARCC_CLK_ALT:  srcTick = ~lowPowerMode & alternate_clock & ~state_reg.altPrev;
            `SARCC_CLK_ASYNC: srcTick = state_reg.asyncCnt == 8'h00;
        endcase
        divMax   = 3'((4'h1 << state_reg.div) - 4'h1);
        adckTick = srcTick && (state_reg.divCnt == divMax);
        if (srcTick) begin
            state_next.divCnt = adckTick ? 3'h0 : state_reg.divCnt + 3'h1;
        end

        nBits   = (state_reg.mode == `SARCC_MODE_10) ? `SARCC_BITS_10 : `SARCC_BITS_8;
        rounded = sarcc_round(state_reg.raw, state_reg.mode == `SARCC_MODE_10);
        cmpRef  = (state_reg.mode == `SARCC_MODE_10) ? state_reg.cmpVal : {2'h0, state_reg.cmpVal[7:0]};
        diff    = rounded - cmpRef;
        cmpTrue = state_reg.cmpGt ? (rounded >= cmpRef) : (rounded < cmpRef);
        keep    = ~state_reg.cmpEn | cmpTrue;
        compareHit = (state_reg.st == ST_STORE) & state_reg.cmpEn & cmpTrue;
        dacTry  = cmpIn ? state_reg.dac : state_reg.dac & ~(11'h001 << state_reg.bitIdx);

        unique case (state_reg.st)
            ST_IDLE: begin
                if (trigEdge && state_reg.hwtEn && !state_reg.series) begin
                    state_next.st      = ST_SAMPLE;
                    state_next.tickCnt = 4'h0;
                    state_next.series  = state_reg.cont;
                end
            end
            ST_SAMPLE: begin
                if (adckTick) begin
                    state_next.tickCnt = state_reg.tickCnt + 4'h1;
                    if (state_reg.tickCnt == `SARCC_SAMPLE_TICKS - 4'h1) begin
                        state_next.st     = ST_CONV;
                        state_next.bitIdx = nBits - 4'h1;
                        state_next.dac    = 11'h001 << (nBits - 4'h1);
                    end
                end
            end
            ST_CONV: begin
                if (adckTick) begin
                    if (state_reg.bitIdx == 4'h0) begin
                        state_next.raw = dacTry;
                        state_next.dac = 11'h000;
                        state_next.st  = ST_STORE;
                    end else begin
                        state_next.dac    = dacTry | (11'h001 << (state_reg.bitIdx - 4'h1));
                        state_next.bitIdx = state_reg.bitIdx - 4'h1;
                    end
                end
            end
            ST_STORE: begin
                if (keep) begin
                    if (state_reg.mode == `SARCC_MODE_10) begin
                        state_next.resHi = state_reg.cmpEn ? diff[9:8] : rounded[9:8];
                    end else begin
                        state_next.resHi = 2'h0;
                    end
                    state_next.resLo = state_reg.cmpEn ? diff[7:0] : rounded[7:0];
                end
                state_next.tickCnt = 4'h0;
                state_next.st = state_reg.cont ? ST_SAMPLE : ST_IDLE;
                if (!state_reg.cont) begin
                    state_next.series = 1'b0;
                end
            end
        endcase

        // Register writes; a write to SC1, SC2, CFG, CMPHI or CMPLO aborts the running conversion
        wrSc1  = busReq.wr && busReq.addr == `SARCC_OFS_SC1;
        wrMode = busReq.wr && (busReq.addr == `SARCC_OFS_SC2 || busReq.addr == `SARCC_OFS_CFG
                 || busReq.addr == `SARCC_OFS_CMPHI || busReq.addr == `SARCC_OFS_CMPLO);
        if (busReq.rd && busReq.addr == `SARCC_OFS_RESLO) begin
            state_next.done = 1'b0;
        end
        if (wrSc1) begin
            state_next.done = 1'b0;
            state_next.ien  = busReq.wdata[`SARCC_SC1_IEN];
            state_next.cont = busReq.wdata[`SARCC_SC1_CONT];
            state_next.ch   = busReq.wdata[4:0];
        end
        if (wrSc1 || wrMode) begin
            state_next.st     = ST_IDLE;
            state_next.series = 1'b0;
            state_next.dac    = 11'h000;
        end
        if (wrSc1 && !state_reg.hwtEn && busReq.wdata[4:0] != `SARCC_CH_OFF) begin
            state_next.st      = ST_SAMPLE;
            state_next.tickCnt = 4'h0;
        end
        if (busReq.wr) begin
            unique case (busReq.addr)
                `SARCC_OFS_SC2: begin
                    state_next.hwtEn = busReq.wdata[`SARCC_SC2_HWTEN];
                    state_next.cmpEn = busReq.wdata[`SARCC_SC2_CMPEN];
                    state_next.cmpGt = busReq.wdata[`SARCC_SC2_CMPGT];
                end
                `SARCC_OFS_CMPHI: state_next.cmpVal[9:8] = busReq.wdata[1:0];
                `SARCC_OFS_CMPLO: state_next.cmpVal[7:0] = busReq.wdata;
                `SARCC_OFS_CFG: begin
                    state_next.div    = busReq.wdata[`SARCC_CFG_DIV +: 2];
                    state_next.mode   = busReq.wdata[`SARCC_CFG_MODE +: 2];
                    state_next.clkSel = busReq.wdata[`SARCC_CFG_CLK +: 2];
                end
                `SARCC_OFS_PINHI: state_next.pinHigh = busReq.wdata;
                default: ;
            endcase
        end

        // Completion sets the flag after a result-read clear in the same cycle, but not with an aborting write
        if (state_reg.st == ST_STORE && keep && !(wrSc1 || wrMode)) begin
            state_next.done = 1'b1;
        end
        if (state_next.ch == `SARCC_CH_OFF) begin
            state_next.st     = ST_IDLE;
            state_next.series = 1'b0;
            state_next.dac    = 11'h000;
        end

        state_next.rdData = 8'h00;
        if (busReq.rd) begin
            unique case (busReq.addr)
                `SARCC_OFS_SC1:   state_next.rdData = {state_reg.done, state_reg.ien,
                                                       state_reg.cont, state_reg.ch};
                `SARCC_OFS_SC2:   state_next.rdData = {1'b0, state_reg.st != ST_IDLE, state_reg.hwtEn,
                                                       state_reg.cmpEn, state_reg.cmpGt, 3'h0};
                `SARCC_OFS_RESHI: state_next.rdData = {6'h00, state_reg.resHi};
                `SARCC_OFS_RESLO: state_next.rdData = state_reg.resLo;
                `SARCC_OFS_CMPHI: state_next.rdData = {6'h00, state_reg.cmpVal[9:8]};
                `SARCC_OFS_CMPLO: state_next.rdData = state_reg.cmpVal[7:0];
                `SARCC_OFS_CFG:   state_next.rdData = {1'b0, state_reg.div, 1'b0,
                                                       state_reg.mode, state_reg.clkSel};
                `SARCC_OFS_PINHI: state_next.rdData = state_reg.pinHigh;
                default:          state_next.rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg        <= '0;
            state_reg.st     <= ST_IDLE;
            state_reg.ch     <= `SARCC_CH_OFF;
            state_reg.clkSel <= `SARCC_CLK_BUS;
        end else begin
            state_reg <= state_next;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_pin_tristate: assert property ((padOe & state_reg.pinHigh) == 8'h00)
        else $error("disabled pin still driven");
    a_port_read_zero: assert property ((gpioIn & state_reg.pinHigh) == 8'h00)
        else $error("disabled pin reads nonzero");
    a_channel_off_idle: assert property (state_reg.ch == `SARCC_CH_OFF |-> state_reg.st == ST_IDLE)
        else $error("converter active with channel off");
    a_idle_power_down: assert property (state_reg.st == ST_IDLE |-> !anaPowerOn && !anaSample)
        else $error("idle converter powered");
    a_ten_bit_store: assert property (state_reg.st == ST_STORE && state_reg.mode == `SARCC_MODE_10
        && !state_reg.cmpEn && !busReq.wr |=> {state_reg.resHi, state_reg.resLo} == $past(rounded))
        else $error("10-bit result not stored rounded");
    a_eight_bit_store: assert property (state_reg.st == ST_STORE && state_reg.mode == `SARCC_MODE_8
        && !busReq.wr |=> state_reg.resHi == 2'h0)
        else $error("8-bit result touched high register");
    a_done_after_store: assert property (state_reg.st == ST_STORE && keep && !busReq.wr
        |=> state_reg.done && (irq == state_reg.ien))
        else $error("done flag not set after store");
    a_reset_bus_clock: assert property ($fell(rst) |-> state_reg.clkSel == `SARCC_CLK_BUS)
        else $error("reset did not select bus clock");
    a_hw_trigger_start: assert property (trigEdge && state_reg.hwtEn && state_reg.st == ST_IDLE
        && !state_reg.series && !busReq.wr && state_reg.ch != `SARCC_CH_OFF |=> state_reg.st == ST_SAMPLE)
        else $error("trigger edge did not start conversion");
    a_trigger_ignored: assert property (trigEdge && state_reg.st == ST_CONV && !adckTick && !busReq.wr
        |=> state_reg.st == ST_CONV && $stable(state_reg.bitIdx))
        else $error("trigger disturbed running conversion");

endmodule

/* File: verification/sarcc_ana_model.sv */
// Behavioural analog core: comparator answering the successive-approximation trials
`timescale 1ns/1ps
module sarcc_ana_model (
    input  wire logic        sys_clk,
    input  wire logic        anaPowerOn,
    input  wire logic [10:0] dacCode,
    input  wire logic [10:0] level,
    output logic             cmpIn
);
    logic idleToggle = 1'b0;

    // An unpowered core gives no answer, so the line wanders instead of holding a value
    always @(posedge sys_clk) begin
        idleToggle <= ~idleToggle;
    end

    assign cmpIn = anaPowerOn ? (level >= dacCode) : idleToggle;
endmodule

/* File: verification/tb.sv */
// Self-checking testbench of the converter control
`timescale 1ns/1ps
module tb;
    import sarcc_pkg::*;
    localparam int ASYNC = 2;
    logic        sys_clk, rst, alternate_clock, lowPowerMode, hwTriggerInput, cmpIn, irq;
    logic        anaPowerOn, anaSample, compareHit, rdSeen;
    sarcc_bus_s  busReq;
    logic [7:0]  rdData, gpioOut, gpioOe, gpioPullEn, padIn, padOut, padOe, padPullEn, gpioIn, p;
    logic [4:0]  anaChannel;
    logic [10:0] dacCode, level;
    logic [9:0]  c;
    logic [7:0]  rdQ[$];
    int          mismatches = 0;
    int          compares = 0;
    int          n;
    int          hits = 0;

    sarcc_top #(.ASYNC_DIV(8'(ASYNC))) uut (.sys_clk(sys_clk), .rst(rst), .busReq(busReq), .rdData(rdData),
        .irq(irq), .alternate_clock(alternate_clock), .lowPowerMode(lowPowerMode), .hwTriggerInput(hwTriggerInput),
        .anaChannel(anaChannel), .anaPowerOn(anaPowerOn), .anaSample(anaSample), .dacCode(dacCode),
        .cmpIn(cmpIn), .compareHit(compareHit), .gpioOut(gpioOut), .gpioOe(gpioOe),
        .gpioPullEn(gpioPullEn), .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullEn(padPullEn),
        .gpioIn(gpioIn));
    sarcc_ana_model model (.sys_clk(sys_clk), .anaPowerOn(anaPowerOn), .dacCode(dacCode), .level(level),
        .cmpIn(cmpIn));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic compare(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED time=%0t got=%h expected=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        busReq.wr <= 1'b0;
    endtask

    // Expected read data is noted here and checked by the monitor below
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        rdQ.push_back(e);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        busReq.rd <= 1'b0;
    endtask

    task automatic waitIdle(output int cnt);
        cnt = 0;
        do begin
            @(posedge sys_clk);
            cnt++;
        end while (anaPowerOn !== 1'b0 && cnt < 2000);
    endtask

    // Start one conversion, time it against the clock ratio and read the stored result back
    task automatic convert(input logic [1:0] clk, input logic [1:0] dv, input logic [1:0] md,
                           input logic [10:0] lvl, input logic [9:0] exp);
        int         cnt;
        int         r;
        int         t;
        logic [4:0] ch;
        ch = 5'($urandom_range(30, 0));
        r = (clk == 2'h0 ? 1 : ASYNC) << dv;
        t = (md == 2'h2) ? 15 : 13;
        level <= lvl;
        wr(4'h6, {1'b0, dv, 1'b0, md, clk});
        wr(4'h0, {3'b010, ch});
        waitIdle(cnt);
        compare(11'(cnt >= (t - 1) * r && cnt <= (t + 1) * r + 4), 11'h1);
        @(posedge sys_clk);
        #1;
        compare(11'(irq), 11'h1);
        compare(11'(anaChannel), 11'(ch));
        rd(4'h0, {3'b110, ch});
        rd(4'h2, {6'h00, exp[9:8]});
        wr(4'h3, ~exp[7:0]);
        rd(4'h3, exp[7:0]);
        rd(4'h0, {3'b010, ch});
        #1;
        compare(11'(anaPowerOn), 11'h0);
    endtask

    always @(posedge sys_clk) begin
        rdSeen <= busReq.rd;
        alternate_clock <= ~alternate_clock;
        if (compareHit === 1'b1) begin
            hits++;
        end
    end

    always @(negedge sys_clk) begin
        if (rdSeen && rdQ.size() > 0) begin
            compare(11'(rdData), 11'(rdQ.pop_front()));
        end
    end

    initial begin
        repeat (50000) @(posedge sys_clk);
        mismatches++;
        summarize();
    end

    initial begin
        busReq = '0;
        {rst, alternate_clock, lowPowerMode, hwTriggerInput, rdSeen} = 5'b10000;
        {gpioOut, gpioOe, gpioPullEn, padIn} = '0;
        level = '0;
        void'($urandom(32'hf2bfd312));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        compare(11'(anaPowerOn), 11'h0);
        rd(4'h0, 8'h1f);
        rd(4'h1, 8'h00);
        rd(4'h6, 8'h00);
        rd(4'h7, 8'h00);
        rd(4'h8, 8'h00);
        for (int i = 0; i < 8; i++) begin
            p = (i < 2) ? (8'h80 >> (7 * i)) : 8'($urandom());
            wr(4'h7, p);
            @(posedge sys_clk);
            {gpioOut, gpioOe, gpioPullEn, padIn} <= 32'($urandom());
            @(posedge sys_clk);
            #1;
            compare(11'(padOe), 11'(gpioOe & ~p));
            compare(11'(padPullEn), 11'(gpioPullEn & ~p));
            compare(11'(gpioIn), 11'(padIn & ~p));
            rd(4'h7, p);
        end
        wr(4'h0, 8'h5f);
        repeat (5) @(posedge sys_clk);
        #1;
        compare(11'(anaPowerOn), 11'h0);
        for (int k = 0; k < 16; k++) begin
            level = 11'($urandom());
            convert(2'(k >> 2), 2'(k), 2'h2, level, (level == 11'h7ff) ? 10'h3ff : 10'((level + 1) >> 1));
        end
        convert(2'h0, 2'h0, 2'h0, 11'h000, 10'h000);
        convert(2'h0, 2'h1, 2'h0, 11'h7ff, 10'h0ff);
        lowPowerMode <= 1'b1;
        convert(2'h3, 2'h1, 2'h2, 11'h2a5, 10'h153);
        wr(4'h6, 8'h02);
        wr(4'h0, 8'h05);
        repeat (100) @(posedge sys_clk);
        #1;
        compare(11'(anaPowerOn), 11'h1);
        wr(4'h6, 8'h02);
        lowPowerMode <= 1'b0;
        #1;
        compare(11'(anaPowerOn), 11'h0);
        c = 10'($urandom_range(511, 8));
        wr(4'h1, 8'h18);
        wr(4'h4, {6'h00, c[9:8]});
        wr(4'h5, c[7:0]);
        convert(2'h0, 2'h0, 2'h2, 11'(2 * (c + 5) - 1), 10'h005);
        compare(11'(hits), 11'h1);
        level <= 11'h000;
        wr(4'h0, 8'h45);
        waitIdle(n);
        @(posedge sys_clk);
        #1;
        compare(11'(irq), 11'h0);
        compare(11'(hits), 11'h1);
        rd(4'h3, 8'h05);
        wr(4'h1, 8'h20);
        level <= 11'h3c1;
        wr(4'h0, 8'h47);
        repeat (5) @(posedge sys_clk);
        #1;
        compare(11'(anaPowerOn), 11'h0);
        @(posedge sys_clk);
        hwTriggerInput <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        compare(11'(anaPowerOn), 11'h0);
        repeat (4) @(posedge sys_clk);
        #1;
        compare(11'(anaPowerOn), 11'h1);
        @(posedge sys_clk);
        hwTriggerInput <= 1'b0;
        repeat (2) @(posedge sys_clk);
        hwTriggerInput <= 1'b1;
        waitIdle(n);
        repeat (20) @(posedge sys_clk);
        #1;
        compare(11'(anaPowerOn), 11'h0);
        compare(11'(irq), 11'h1);
        rd(4'h3, 8'he1);
        hwTriggerInput <= 1'b0;
        repeat (4) @(posedge sys_clk);
        summarize();
    end
endmodule
